// ==== verilog/brtr_pkg.sv ====
// Package: constants and carrier types for the baud rate timer with reload
package brtr_pkg;
   // ****************************************
   // Widths
   // ****************************************
   localparam int BRTR_CNT_W = 16;
   localparam int BRTR_BYTE_W = 8;
   localparam int BRTR_PRE_W = 4;

   // ****************************************
   // Prescale counts (oscillator clocks per increment)
   // ****************************************
   localparam logic [3:0] BRTR_MACHINE_DIV = 4'hC;
   localparam logic [3:0] BRTR_STATE_DIV = 4'h2;
   localparam logic [3:0] BRTR_PRE_RESET = 4'h0;

   // ****************************************
   // Serial clock division
   // ****************************************
   localparam logic [3:0] BRTR_SERIAL_DIV = 4'hF;
   localparam logic [3:0] BRTR_SDIV_RESET = 4'h0;

   // ****************************************
   // Count reset value and count maximum
   // ****************************************
   localparam logic [15:0] BRTR_COUNT_RESET = 16'h0000;
   localparam logic [15:0] BRTR_COUNT_MAX = 16'hFFFF;

   typedef enum logic {
      BRTR_SRC_FIRST_TIMER,
      BRTR_SRC_THIS_TIMER
   } brtr_src_t;

   // Control bits of the second timer control group
   typedef struct packed {
      logic tx_baud_source_sel;
      logic rx_baud_source_sel;
      logic count_or_time_sel;
      logic ext_trigger_enable;
      logic run_enable;
   } brtr_ctrl_t;

   // Reload value pair
   typedef struct packed {
      logic [7:0] reload_value_high;
      logic [7:0] reload_value_low;
   } brtr_reload_t;

   // Serial baud clocks delivered to the serial port
   typedef struct packed {
      logic tx_baud_tick;
      logic rx_baud_tick;
   } brtr_baud_t;

   // Baud mode decode, called by the main file only; leaves get it as a port
   function automatic logic brtr_baud_mode(input brtr_ctrl_t c);
      return c.tx_baud_source_sel | c.rx_baud_source_sel;
   endfunction : brtr_baud_mode
endpackage : brtr_pkg

// ==== verilog/brtr_prescale.sv ====
// Prescaler: issues count ticks at machine-cycle or state-time rate
`timescale 1ns/1ps
module brtr_prescale
   import brtr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic run,
   input wire logic baud_mode,
   output logic tick
);
   logic [3:0] pre_cnt;
   logic [3:0] pre_div;

   assign pre_div = baud_mode ? BRTR_STATE_DIV : BRTR_MACHINE_DIV;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pre_cnt <= BRTR_PRE_RESET;
         tick <= 1'b0;
      end else if (clk_en) begin
         // Restart on halt so the first tick after run is a full period
         if (!run) begin
            pre_cnt <= BRTR_PRE_RESET;
            tick <= 1'b0;
         end else if (pre_cnt >= pre_div - 4'h1) begin
            pre_cnt <= BRTR_PRE_RESET;
            tick <= 1'b1;
         end else begin
            pre_cnt <= pre_cnt + 4'h1;
            tick <= 1'b0;
         end
      end
      // Tick held while frozen, so no increment is lost across a stall
   end
endmodule : brtr_prescale

// ==== verilog/brtr_fall_detect.sv ====
// Falling edge detector for a synchronous pin input
`timescale 1ns/1ps
module brtr_fall_detect (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic pin,
   output logic fall
);
   logic pin_q;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pin_q <= 1'b1;
         fall <= 1'b0;
      end else if (clk_en) begin
         pin_q <= pin;
         fall <= pin_q & ~pin;
      end
   end
endmodule : brtr_fall_detect

// ==== verilog/brtr_timer.sv ====
// Main file: 16-bit auto-reload timer acting as serial baud generator
`timescale 1ns/1ps

// Functional notes
// - The transmit baud clock comes from the first timer when its select is 0, from this one when 1.
// - The receive select picks its source the same way, independent of transmit.
// - In baud mode every high-byte rollover reloads both count bytes from the reload pair.
// - The reload pair is one 16-bit unsigned value, high register on top.
// - For serial modes 1 and 3 the baud clock is this timer's overflow rate divided by 16.
// - The count-or-time select picks counter operation when 1 and timer operation when 0.
// - Outside baud mode, timer operation increments once per twelve oscillator clocks.
// - In baud mode, timer operation increments once per two oscillator clocks.
// - Baud behaviour is active only while either receive or transmit select is 1.
// - In baud mode a rollover sets no overflow flag and raises no timer interrupt.
// - In baud mode with trigger enable set, a falling trigger edge sets the flag, no reload.
// - The trigger input and its flag stay usable as an extra interrupt source in baud mode.
module brtr_timer
   import brtr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire brtr_ctrl_t second_timer_control,
   input wire brtr_reload_t reload_pair,
   input wire logic count_load,
   input wire logic [15:0] count_load_value,
   input wire logic overflow_flag_clr,
   input wire logic ext_trigger_flag_clr,
   input wire logic ext_trigger_input,
   input wire logic count_pin,
   input wire brtr_baud_t first_timer_baud,
   output brtr_baud_t serial_baud,
   output logic [7:0] timer_count_high,
   output logic [7:0] timer_count_low,
   output logic overflow_flag,
   output logic ext_trigger_flag,
   output logic timer_irq,
   output logic baud_mode_active
);
   // ****************************************
   // Mode decode
   // ****************************************
   logic baud_mode;
   logic pre_tick;
   logic count_fall;
   logic trig_fall;
   logic inc;
   logic rollover;
   logic [15:0] count;
   logic [15:0] reload_value;
   logic [15:0] next_count;
   logic [3:0] sdiv;
   logic baud_tick_raw;

   assign baud_mode = brtr_baud_mode(second_timer_control);
   assign reload_value = {reload_pair.reload_value_high,
                          reload_pair.reload_value_low};

   // ****************************************
   // Increment sources
   // ****************************************
   brtr_prescale u_prescale (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .run(second_timer_control.run_enable),
      .baud_mode(baud_mode),
      .tick(pre_tick)
   );

   brtr_fall_detect u_count_edge (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .pin(count_pin),
      .fall(count_fall)
   );

   brtr_fall_detect u_trig_edge (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .pin(ext_trigger_input),
      .fall(trig_fall)
   );

   // Counter operation counts pin falls; timer operation counts prescale ticks
   assign inc = second_timer_control.run_enable &
                (second_timer_control.count_or_time_sel ? count_fall : pre_tick);
   assign rollover = inc && (count == BRTR_COUNT_MAX);

   // ****************************************
   // Count register
   // ****************************************
   always_comb begin
      next_count = count;
      if (count_load) begin
         next_count = count_load_value;
      end else if (inc) begin
         // Reload on rollover in baud mode; plain wrap otherwise
         if (rollover && baud_mode) begin
            next_count = reload_value;
         end else begin
            next_count = count + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         count <= BRTR_COUNT_RESET;
      end else if (clk_en) begin
         count <= next_count;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         timer_count_high <= BRTR_COUNT_RESET[15:8];
         timer_count_low <= BRTR_COUNT_RESET[7:0];
      end else if (clk_en) begin
         timer_count_high <= next_count[15:8];
         timer_count_low <= next_count[7:0];
      end
   end

   // ****************************************
   // Flags
   // ****************************************
   // Set wins over clear so no event is lost
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         overflow_flag <= 1'b0;
      end else if (clk_en) begin
         if (rollover && !baud_mode) begin
            overflow_flag <= 1'b1;
         end else if (overflow_flag_clr) begin
            overflow_flag <= 1'b0;
         end
      end
   end

   // The trigger never reloads the count here, in any mode
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ext_trigger_flag <= 1'b0;
      end else if (clk_en) begin
         if (trig_fall && second_timer_control.ext_trigger_enable) begin
            ext_trigger_flag <= 1'b1;
         end else if (ext_trigger_flag_clr) begin
            ext_trigger_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         timer_irq <= 1'b0;
         baud_mode_active <= 1'b0;
      end else if (clk_en) begin
         timer_irq <= overflow_flag | ext_trigger_flag;
         baud_mode_active <= baud_mode;
      end
   end

   // ****************************************
   // Baud clock generation
   // ****************************************
   // Divide by 16: with two clocks per count this gives osc/(32*(65536-reload))
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sdiv <= BRTR_SDIV_RESET;
         baud_tick_raw <= 1'b0;
      end else if (clk_en) begin
         baud_tick_raw <= 1'b0;
         if (rollover && baud_mode) begin
            if (sdiv == BRTR_SERIAL_DIV) begin
               sdiv <= BRTR_SDIV_RESET;
               baud_tick_raw <= 1'b1;
            end else begin
               sdiv <= sdiv + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         serial_baud <= '0;
      end else if (clk_en) begin
         serial_baud.tx_baud_tick <= second_timer_control.tx_baud_source_sel ?
                                     baud_tick_raw : first_timer_baud.tx_baud_tick;
         serial_baud.rx_baud_tick <= second_timer_control.rx_baud_source_sel ?
                                     baud_tick_raw : first_timer_baud.rx_baud_tick;
      end else begin
         serial_baud <= '0;
      end
   end
endmodule : brtr_timer

// ==== verif/brtr_serial_model.sv ====
// Serial port stand-in: first timer ticks out, delivered baud ticks counted
`timescale 1ns/1ps
module brtr_serial_model
   import brtr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire brtr_baud_t serial_baud,
   output brtr_baud_t first_timer_baud,
   output int tx_n,
   output int rx_n
);
   logic [3:0] div;
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         div <= 4'h0;
         first_timer_baud <= '0;
         tx_n <= 0;
         rx_n <= 0;
      end else begin
         div <= (div == 4'h9) ? 4'h0 : div + 4'h1;
         // Tx period 5, rx period 10, so a wrong source shows in the counts
         first_timer_baud.tx_baud_tick <= (div == 4'h0) || (div == 4'h5);
         first_timer_baud.rx_baud_tick <= (div == 4'h0);
         tx_n <= tx_n + int'(serial_baud.tx_baud_tick);
         rx_n <= rx_n + int'(serial_baud.rx_baud_tick);
      end
   end
endmodule : brtr_serial_model

// ==== verif/brtr_timer_chk.sv ====
// Port assertions for the baud rate timer
`timescale 1ns/1ps
module brtr_timer_chk
   import brtr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire brtr_ctrl_t second_timer_control,
   input wire brtr_reload_t reload_pair,
   input wire logic count_load,
   input wire logic ext_trigger_input,
   input wire brtr_baud_t first_timer_baud,
   input wire brtr_baud_t serial_baud,
   input wire logic [7:0] timer_count_high,
   input wire logic [7:0] timer_count_low,
   input wire logic overflow_flag,
   input wire logic ext_trigger_flag,
   input wire logic timer_irq,
   input wire logic baud_mode_active
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   wire logic [15:0] cnt = {timer_count_high, timer_count_low};
   wire logic tmr = second_timer_control.run_enable && !second_timer_control.count_or_time_sel;
   AST_BAUD_ACTIVE: assert property (!$past(sys_rst) |-> baud_mode_active ==
      $past(second_timer_control.tx_baud_source_sel | second_timer_control.rx_baud_source_sel))
      else $error("baud mode flag wrong");
   AST_TX_SRC: assert property (!$past(sys_rst) && $past(!second_timer_control.tx_baud_source_sel)
      |-> serial_baud.tx_baud_tick == $past(first_timer_baud.tx_baud_tick))
      else $error("tx tick not from first timer");
   AST_RX_SRC: assert property (!$past(sys_rst) && $past(!second_timer_control.rx_baud_source_sel)
      |-> serial_baud.rx_baud_tick == $past(first_timer_baud.rx_baud_tick))
      else $error("rx tick not from first timer");
   AST_RELOAD: assert property ($past(baud_mode_active && cnt == 16'hFFFF && !count_load)
      && $changed(cnt) |-> cnt == $past(reload_pair)) else $error("reload value wrong");
   AST_NO_OVF: assert property (baud_mode_active && $past(baud_mode_active)
      |-> !$rose(overflow_flag)) else $error("overflow flag set in baud mode");
   AST_WRAP: assert property ($past(!baud_mode_active && cnt == 16'hFFFF && !count_load)
      && cnt == 16'h0000 |-> overflow_flag) else $error("wrap without overflow flag");
   // A software load may land inside the quiet window and beats the count
   AST_BAUD_STEP: assert property (baud_mode_active && tmr && $changed(cnt)
      |=> $stable(cnt) || $past(count_load)) else $error("baud increment too fast");
   AST_TIMER_STEP: assert property (!baud_mode_active && tmr && $changed(cnt)
      |=> ($stable(cnt) || $past(count_load)) [*8]) else $error("timer increment too fast");
   AST_IRQ: assert property (!$past(sys_rst) |-> timer_irq ==
      $past(overflow_flag | ext_trigger_flag)) else $error("irq mismatch");
   AST_EXT_FLAG: assert property (second_timer_control.ext_trigger_enable
      && $fell(ext_trigger_input) |-> ##[1:4] ext_trigger_flag) else $error("trigger flag late");
endmodule : brtr_timer_chk
bind brtr_timer brtr_timer_chk i_brtr_timer_chk (.clk_sys, .sys_rst, .second_timer_control,
   .reload_pair, .count_load, .ext_trigger_input, .first_timer_baud, .serial_baud,
   .timer_count_high, .timer_count_low, .overflow_flag, .ext_trigger_flag, .timer_irq,
   .baud_mode_active);

// ==== verif/brtr_timer_tb_top.sv ====
// Testbench for the baud rate timer
`timescale 1ns/1ps
module brtr_timer_tb_top;
   import brtr_pkg::*;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   brtr_ctrl_t ctl = '0;
   brtr_reload_t rel = '0;
   logic ld = 1'b0;
   logic [15:0] ldv = 16'h0000;
   logic ovc = 1'b0;
   logic exc = 1'b0;
   logic trg = 1'b1;
   logic pin = 1'b1;
   brtr_baud_t ftb, sb;
   logic [7:0] th, tl;
   logic ovf, exf, irq, bma;
   int tx_n, rx_n, n_errors = 0, total_checks = 0;
   wire logic [15:0] cnt = {th, tl};
   always #2 clk_sys = ~clk_sys;
   brtr_timer i_brtr_timer (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
      .second_timer_control(ctl), .reload_pair(rel), .count_load(ld), .count_load_value(ldv),
      .overflow_flag_clr(ovc), .ext_trigger_flag_clr(exc), .ext_trigger_input(trg),
      .count_pin(pin), .first_timer_baud(ftb), .serial_baud(sb), .timer_count_high(th),
      .timer_count_low(tl), .overflow_flag(ovf), .ext_trigger_flag(exf), .timer_irq(irq),
      .baud_mode_active(bma));
   brtr_serial_model i_brtr_serial_model (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .serial_baud(sb), .first_timer_baud(ftb), .tx_n(tx_n), .rx_n(rx_n));
   // ****
   // Helpers
   // ****
   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys) #1;
   endtask : cyc
   // Edges until the count moves; bounded so a stuck timer cannot hang
   task automatic step(output int n);
      logic [15:0] c0;
      c0 = cnt;
      n = 0;
      while (cnt === c0 && n < 40) begin
         cyc(1);
         n++;
      end
      if (n >= 40) begin
         n_errors++;
         close_out();
      end
   endtask : step
   // Count preset while stopped, then control applied
   task automatic setup(input brtr_ctrl_t c, input logic [15:0] v);
      @(posedge clk_sys) ld <= 1'b1;
      ldv <= v;
      ctl <= c & 5'h1E;
      @(posedge clk_sys) ld <= 1'b0;
      ctl <= c;
      cyc(1);
   endtask : setup
   task automatic pulse_pins(input logic t, input logic p);
      @(posedge clk_sys) trg <= t;
      pin <= p;
      @(posedge clk_sys) trg <= 1'b1;
      pin <= 1'b1;
      cyc(4);
   endtask : pulse_pins
   // ****
   // Scenarios
   // ****
   task automatic t_rates(input brtr_ctrl_t c, input logic [15:0] etx, input logic [15:0] erx);
      int k_tx, k_rx;
      rel <= 16'hFFFF;
      setup(c, 16'hFFFF);
      cyc(40);
      k_tx = tx_n;
      k_rx = rx_n;
      cyc(320);
      chk(16'(tx_n - k_tx), etx);
      chk(16'(rx_n - k_rx), erx);
      chk(ovf, 1'b0);
      $display("rates done");
   endtask : t_rates
   task automatic t_reload;
      int n;
      rel <= 16'hA55A;
      setup(5'h11, 16'hFFFE);
      step(n);
      step(n);
      chk(16'(n), 16'h0002);
      chk(cnt, 16'hA55A);
      chk(ovf, 1'b0);
      chk(bma, 1'b1);
      $display("reload done");
   endtask : t_reload
   // Stall mid-count: the pending step must come on the first enabled edge
   task automatic t_freeze;
      logic [15:0] c1;
      int n;
      setup(5'h19, 16'hFFF0);
      step(n);
      c1 = cnt;
      @(posedge clk_sys) clk_en <= 1'b0;
      cyc(10);
      chk(cnt, c1);
      @(posedge clk_sys) clk_en <= 1'b1;
      step(n);
      chk(16'(n), 16'h0001);
      chk(cnt, c1 + 16'h0001);
      $display("freeze done");
   endtask : t_freeze
   task automatic t_wrap;
      int n;
      setup(5'h01, 16'hFFFE);
      step(n);
      step(n);
      chk(16'(n), 16'h000C);
      chk(cnt, 16'h0000);
      chk(ovf, 1'b1);
      cyc(1);
      chk(irq, 1'b1);
      @(posedge clk_sys) ovc <= 1'b1;
      @(posedge clk_sys) ovc <= 1'b0;
      cyc(2);
      chk(ovf, 1'b0);
      $display("wrap done");
   endtask : t_wrap
   task automatic t_trigger;
      setup(5'h12, 16'h1234);
      pulse_pins(1'b0, 1'b1);
      chk(exf, 1'b1);
      chk(cnt, 16'h1234);
      chk(irq, 1'b1);
      @(posedge clk_sys) exc <= 1'b1;
      ctl <= 5'h10;
      @(posedge clk_sys) exc <= 1'b0;
      pulse_pins(1'b0, 1'b1);
      chk(exf, 1'b0);
      $display("trigger done");
   endtask : t_trigger
   task automatic t_counter;
      setup(5'h05, 16'h0000);
      repeat (3) pulse_pins(1'b1, 1'b0);
      chk(cnt, 16'h0003);
      $display("counter done");
   endtask : t_counter
   initial begin
      cyc(3);
      @(posedge clk_sys) sys_rst <= 1'b0;
      cyc(1);
      t_rates(5'h11, 16'h000A, 16'h0020);
      t_rates(5'h09, 16'h0040, 16'h000A);
      t_reload();
      t_freeze();
      t_wrap();
      t_trigger();
      t_counter();
      close_out();
   end
endmodule : brtr_timer_tb_top
